// >>> rtl/trigger_seq_pkg.sv
/*
 * constants shared by the trigger sequencer register bank: register
 * addresses, field positions, reset values and step command codes.
 * assumes a 16-bit software data path and a 6-bit word address.
 */
package trigger_seq_pkg;

    // ------------------------------------------------------------
    // widths
    // ------------------------------------------------------------
    localparam int DATA_W = 16;
    localparam int ADDR_W = 6;
    localparam int PTR_W = 5;
    localparam int QUEUE_WORDS = 16;

    // ------------------------------------------------------------
    // register word addresses
    // ------------------------------------------------------------
    localparam logic [5:0] ADDR_BCAST_MASK = 6'h00;
    localparam logic [5:0] ADDR_TIMER0_LIM = 6'h01;
    localparam logic [5:0] ADDR_TIMER1_LIM = 6'h02;
    localparam logic [5:0] ADDR_SDELAY_LIM = 6'h03;
    localparam logic [5:0] ADDR_COUNT0_LIM = 6'h04;
    localparam logic [5:0] ADDR_COUNT1_LIM = 6'h05;
    localparam logic [5:0] ADDR_HOLD = 6'h06;
    localparam logic [5:0] ADDR_ADJUST = 6'h07;
    localparam logic [5:0] ADDR_LITERAL = 6'h08;
    localparam logic [5:0] ADDR_POINTER = 6'h09;
    // queue words occupy 0x10..0x1f, word index in the low four bits
    localparam logic [1:0] ADDR_QUEUE_TOP = 2'h1;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int MASK_ADC_LSB = 12;
    localparam int MASK_ICSYNC_LSB = 8;
    localparam int MASK_OCCLK_LSB = 4;
    localparam int MASK_OCSYNC_LSB = 0;
    localparam int STEP_ODD_LSB = 8;
    localparam int STEP_EVEN_LSB = 0;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [15:0] REG_RESET = 16'h0000;
    localparam logic [4:0] PTR_RESET = 5'h00;

    // ------------------------------------------------------------
    // step command codes (upper nibble) and options (lower nibble)
    // ------------------------------------------------------------
    localparam logic [3:0] CMD_CONTROL = 4'h0;
    localparam logic [3:0] CMD_ADD_COPY = 4'h1;
    localparam logic [3:0] OPT_CH_FROM_C0 = 4'hc;
    localparam logic [3:0] OPT_CH_FROM_C1 = 4'hd;
    localparam logic [3:0] OPT_CH_FROM_LIT = 4'he;
    localparam logic [3:0] OPT_BROADCAST = 4'hf;

    // target selectors in option bits 2..0 for add and copy
    localparam logic [2:0] TGT_COUNT0 = 3'h0;
    localparam logic [2:0] TGT_COUNT1 = 3'h1;
    localparam logic [2:0] TGT_TIMER0 = 3'h2;
    localparam logic [2:0] TGT_TIMER1 = 3'h3;
    localparam logic [2:0] TGT_SDELAY = 3'h4;
    localparam logic [2:0] TGT_LITERAL = 3'h5;

    // base step delay added to the programmed limit
    localparam logic [16:0] STEP_DELAY_BASE = 17'h00001;

endpackage

// >>> rtl/trigger_seq_regs.sv
/*
 * register bank of the trigger sequencer: broadcast mask, limits,
 * hold, adjust, literal, step pointer and the step queue.  it also
 * carries out the register-side effects of executed steps.
 * assumes the sequencer core on the same clock drives the enable,
 * start, visibility, live count and step execute inputs.
 */
`timescale 1ns/10ps

// Overview of operation
// - mask bits 15-12 fire converter sample triggers
// - mask bits 11-8 fire capture sync pulses
// - mask bits 7-4 fire compare clock pulses
// - mask bits 3-0 fire compare sync pulses
// - mask used only by broadcast control option
// - enable and start make bank read-only
// - two 16-bit timer limit registers, reset zero
// - effective step delay is limit plus one
// - counter limits give loop counts for jumps
// - copy step loads hold value into target
// - add step sums adjust value into target
// - control step sends literal or a counter limit to channel select
// - 5-bit pointer, upper bits read zero
// - queue word holds odd step high, even low
// - visibility bit returns live counts on reads
// - step byte is command nibble plus option
module trigger_seq_regs
    import trigger_seq_pkg::*;
(
    // clock and reset
    input wire logic i_ref_clk,
    input wire logic i_rst,
    // software register port
    input wire logic [5:0] i_addr,
    input wire logic [15:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [15:0] o_rdata,
    // control bits from the sequencer core
    input wire logic i_module_enable_bit,
    input wire logic i_sequencer_start_bit,
    input wire logic i_live_count_visibility,
    // live counter and timer values
    input wire logic [15:0] i_timer0_count,
    input wire logic [15:0] i_timer1_count,
    input wire logic [15:0] i_step_delay_count,
    input wire logic [15:0] i_counter0_count,
    input wire logic [15:0] i_counter1_count,
    // step execution and pointer update from the core
    input wire logic i_step_execute,
    input wire logic i_pointer_load,
    input wire logic [4:0] i_pointer_value,
    // current step to the core
    output logic [3:0] o_step_command,
    output logic [3:0] o_step_option,
    output logic [4:0] o_step_index_pointer,
    // limits to the core
    output logic [15:0] o_timer0_limit,
    output logic [15:0] o_timer1_limit,
    output logic [16:0] o_step_delay_total,
    output logic [15:0] o_counter0_limit,
    output logic [15:0] o_counter1_limit,
    // broadcast trigger pulses
    output logic [3:0] o_converter_sample_trigger,
    output logic [3:0] o_capture_sync_pulse,
    output logic [3:0] o_compare_clock_pulse,
    output logic [3:0] o_compare_sync_pulse,
    // converter channel select write port
    output logic [15:0] o_converter_channel_select,
    output logic o_converter_channel_strobe
);

    // ------------------------------------------------------------
    // storage
    // ------------------------------------------------------------
    logic [15:0] broadcast_trigger_mask;
    logic [15:0] timer0_limit;
    logic [15:0] timer1_limit;
    logic [15:0] step_delay_limit;
    logic [15:0] counter0_limit;
    logic [15:0] counter1_limit;
    logic [15:0] copy_source_value;
    logic [15:0] add_operand_value;
    logic [15:0] channel_literal_value;
    logic [4:0] step_index_pointer;
    logic [15:0] step_pair_storage [QUEUE_WORDS];

    logic running;
    logic sw_write;
    logic [7:0] cur_step;
    logic [3:0] cur_cmd;
    logic [3:0] cur_opt;
    logic exec_add;
    logic exec_copy;
    logic exec_bcast;
    logic exec_chsel;

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    // next value of one add/copy target; only one step runs per cycle
    function automatic logic [15:0] step_update(
        input logic [15:0] cur,
        input logic [2:0] tgt,
        input logic [2:0] sel,
        input logic do_add,
        input logic do_copy,
        input logic [15:0] hold,
        input logic [15:0] adj
    );
        logic [15:0] res;
        res = cur;
        if (do_copy && (sel == tgt)) begin
            res = hold;
        end else if (do_add && (sel == tgt)) begin
            res = 16'(cur + adj);
        end
        return res;
    endfunction

    // software write strobe for one word address
    function automatic logic wr_hit(
        input logic wr_en,
        input logic [5:0] addr,
        input logic [5:0] target
    );
        return wr_en && (addr == target);
    endfunction

    // ------------------------------------------------------------
    // step decode
    // ------------------------------------------------------------
    // bank ignores software writes while the sequencer runs
    assign running = i_module_enable_bit && i_sequencer_start_bit;
    assign sw_write = i_wr && !running;

    // odd steps sit in the high byte, even steps in the low byte
    assign cur_step = step_index_pointer[0]
        ? step_pair_storage[step_index_pointer[4:1]][STEP_ODD_LSB +: 8]
        : step_pair_storage[step_index_pointer[4:1]][STEP_EVEN_LSB +: 8];
    assign cur_cmd = cur_step[7:4];
    assign cur_opt = cur_step[3:0];

    // step effects only count while actually running
    assign exec_add = running && i_step_execute && (cur_cmd == CMD_ADD_COPY)
        && !cur_opt[3];
    assign exec_copy = running && i_step_execute && (cur_cmd == CMD_ADD_COPY)
        && cur_opt[3];
    assign exec_bcast = running && i_step_execute && (cur_cmd == CMD_CONTROL)
        && (cur_opt == OPT_BROADCAST);
    assign exec_chsel = running && i_step_execute && (cur_cmd == CMD_CONTROL)
        && ((cur_opt == OPT_CH_FROM_C0) || (cur_opt == OPT_CH_FROM_C1)
        || (cur_opt == OPT_CH_FROM_LIT));

    // ------------------------------------------------------------
    // broadcast mask, hold and adjust
    // ------------------------------------------------------------
    // plain software registers, never touched by steps
    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            broadcast_trigger_mask <= REG_RESET;
            copy_source_value <= REG_RESET;
            add_operand_value <= REG_RESET;
        end else begin
            if (wr_hit(sw_write, i_addr, ADDR_BCAST_MASK)) begin
                broadcast_trigger_mask <= i_wdata;
            end
            if (wr_hit(sw_write, i_addr, ADDR_HOLD)) begin
                copy_source_value <= i_wdata;
            end
            if (wr_hit(sw_write, i_addr, ADDR_ADJUST)) begin
                add_operand_value <= i_wdata;
            end
        end
    end

    // ------------------------------------------------------------
    // limits and literal
    // ------------------------------------------------------------
    // software and step writes never meet: steps need running,
    // software writes need the bank stopped
    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            timer0_limit <= REG_RESET;
            timer1_limit <= REG_RESET;
            step_delay_limit <= REG_RESET;
            counter0_limit <= REG_RESET;
            counter1_limit <= REG_RESET;
            channel_literal_value <= REG_RESET;
        end else if (sw_write) begin
            if (i_addr == ADDR_TIMER0_LIM) begin
                timer0_limit <= i_wdata;
            end
            if (i_addr == ADDR_TIMER1_LIM) begin
                timer1_limit <= i_wdata;
            end
            if (i_addr == ADDR_SDELAY_LIM) begin
                step_delay_limit <= i_wdata;
            end
            if (i_addr == ADDR_COUNT0_LIM) begin
                counter0_limit <= i_wdata;
            end
            if (i_addr == ADDR_COUNT1_LIM) begin
                counter1_limit <= i_wdata;
            end
            if (i_addr == ADDR_LITERAL) begin
                channel_literal_value <= i_wdata;
            end
        end else begin
            timer0_limit <= step_update(timer0_limit, TGT_TIMER0, cur_opt[2:0],
                exec_add, exec_copy, copy_source_value, add_operand_value);
            timer1_limit <= step_update(timer1_limit, TGT_TIMER1, cur_opt[2:0],
                exec_add, exec_copy, copy_source_value, add_operand_value);
            step_delay_limit <= step_update(step_delay_limit, TGT_SDELAY,
                cur_opt[2:0], exec_add, exec_copy, copy_source_value,
                add_operand_value);
            counter0_limit <= step_update(counter0_limit, TGT_COUNT0,
                cur_opt[2:0], exec_add, exec_copy, copy_source_value,
                add_operand_value);
            counter1_limit <= step_update(counter1_limit, TGT_COUNT1,
                cur_opt[2:0], exec_add, exec_copy, copy_source_value,
                add_operand_value);
            channel_literal_value <= step_update(channel_literal_value,
                TGT_LITERAL, cur_opt[2:0], exec_add, exec_copy,
                copy_source_value, add_operand_value);
        end
    end

    // ------------------------------------------------------------
    // step pointer
    // ------------------------------------------------------------
    // the core advances or jumps the pointer only while running
    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            step_index_pointer <= PTR_RESET;
        end else if (wr_hit(sw_write, i_addr, ADDR_POINTER)) begin
            step_index_pointer <= i_wdata[PTR_W-1:0];
        end else if (running && i_pointer_load) begin
            step_index_pointer <= i_pointer_value;
        end
    end

    // ------------------------------------------------------------
    // step queue
    // ------------------------------------------------------------
    // reset loop keeps the array free of unknowns at start
    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            for (int i = 0; i < QUEUE_WORDS; i++) begin
                step_pair_storage[i] <= REG_RESET;
            end
        end else if (sw_write && (i_addr[5:4] == ADDR_QUEUE_TOP)) begin
            step_pair_storage[i_addr[3:0]] <= i_wdata;
        end
    end

    // ------------------------------------------------------------
    // read port
    // ------------------------------------------------------------
    // data stands only in the cycle after the strobe; unmapped reads zero
    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            o_rdata <= REG_RESET;
        end else if (!i_rd) begin
            o_rdata <= REG_RESET;
        end else if (i_addr[5:4] == ADDR_QUEUE_TOP) begin
            o_rdata <= step_pair_storage[i_addr[3:0]];
        end else begin
            unique case (i_addr)
                ADDR_BCAST_MASK: o_rdata <= broadcast_trigger_mask;
                ADDR_TIMER0_LIM: o_rdata <= i_live_count_visibility
                    ? i_timer0_count : timer0_limit;
                ADDR_TIMER1_LIM: o_rdata <= i_live_count_visibility
                    ? i_timer1_count : timer1_limit;
                ADDR_SDELAY_LIM: o_rdata <= i_live_count_visibility
                    ? i_step_delay_count : step_delay_limit;
                ADDR_COUNT0_LIM: o_rdata <= i_live_count_visibility
                    ? i_counter0_count : counter0_limit;
                ADDR_COUNT1_LIM: o_rdata <= i_live_count_visibility
                    ? i_counter1_count : counter1_limit;
                ADDR_HOLD: o_rdata <= copy_source_value;
                ADDR_ADJUST: o_rdata <= add_operand_value;
                ADDR_LITERAL: o_rdata <= channel_literal_value;
                ADDR_POINTER: o_rdata <= {11'h000, step_index_pointer};
                default: o_rdata <= REG_RESET;
            endcase
        end
    end

    // ------------------------------------------------------------
    // current step and limits to the core
    // ------------------------------------------------------------
    // registered copies: one cycle behind the stored values; the step delay total is the limit plus one
    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            o_step_command <= 4'h0;
            o_step_option <= 4'h0;
            o_step_index_pointer <= PTR_RESET;
            o_timer0_limit <= REG_RESET;
            o_timer1_limit <= REG_RESET;
            o_step_delay_total <= STEP_DELAY_BASE;
            o_counter0_limit <= REG_RESET;
            o_counter1_limit <= REG_RESET;
        end else begin
            o_step_command <= cur_cmd;
            o_step_option <= cur_opt;
            o_step_index_pointer <= step_index_pointer;
            o_timer0_limit <= timer0_limit;
            o_timer1_limit <= timer1_limit;
            o_step_delay_total <= {1'b0, step_delay_limit} + STEP_DELAY_BASE;
            o_counter0_limit <= counter0_limit;
            o_counter1_limit <= counter1_limit;
        end
    end

    // ------------------------------------------------------------
    // broadcast triggers
    // ------------------------------------------------------------
    // one-cycle pulses for the set mask bits, no other step uses the mask
    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            o_converter_sample_trigger <= 4'h0;
            o_capture_sync_pulse <= 4'h0;
            o_compare_clock_pulse <= 4'h0;
            o_compare_sync_pulse <= 4'h0;
        end else if (exec_bcast) begin
            o_converter_sample_trigger <= broadcast_trigger_mask[MASK_ADC_LSB +: 4];
            o_capture_sync_pulse <= broadcast_trigger_mask[MASK_ICSYNC_LSB +: 4];
            o_compare_clock_pulse <= broadcast_trigger_mask[MASK_OCCLK_LSB +: 4];
            o_compare_sync_pulse <= broadcast_trigger_mask[MASK_OCSYNC_LSB +: 4];
        end else begin
            o_converter_sample_trigger <= 4'h0;
            o_capture_sync_pulse <= 4'h0;
            o_compare_clock_pulse <= 4'h0;
            o_compare_sync_pulse <= 4'h0;
        end
    end

    // ------------------------------------------------------------
    // converter channel select
    // ------------------------------------------------------------
    // data holds after the strobe so a slow consumer may sample late
    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            o_converter_channel_select <= REG_RESET;
            o_converter_channel_strobe <= 1'b0;
        end else begin
            o_converter_channel_strobe <= exec_chsel;
            if (exec_chsel) begin
                if (cur_opt == OPT_CH_FROM_C0) begin
                    o_converter_channel_select <= counter0_limit;
                end else if (cur_opt == OPT_CH_FROM_C1) begin
                    o_converter_channel_select <= counter1_limit;
                end else begin
                    o_converter_channel_select <= channel_literal_value;
                end
            end
        end
    end

endmodule

// >>> tb/trigger_seq_regs_checker.sv
/*
 * concurrent checks on the ports of the trigger sequencer register bank.
 * assumes the package and the bank are compiled first; bound below.
 */
`timescale 1ns/10ps
module trigger_seq_regs_checker
    import trigger_seq_pkg::*;
(
    // clock, reset, register port
    input logic i_ref_clk,
    input logic i_rst,
    input logic [5:0] i_addr,
    input logic i_rd,
    input logic [15:0] o_rdata,
    // core side
    input logic i_module_enable_bit,
    input logic i_sequencer_start_bit,
    input logic i_live_count_visibility,
    input logic [15:0] i_timer0_count,
    input logic i_step_execute,
    input logic i_pointer_load,
    input logic [4:0] i_pointer_value,
    // bank outputs
    input logic [4:0] o_step_index_pointer,
    input logic [15:0] o_timer0_limit,
    input logic [16:0] o_step_delay_total,
    input logic [3:0] o_converter_sample_trigger,
    input logic [3:0] o_capture_sync_pulse,
    input logic [3:0] o_compare_clock_pulse,
    input logic [3:0] o_compare_sync_pulse
);
    // ----------------------------------------
    // helpers and properties
    // ----------------------------------------
    wire run = i_module_enable_bit & i_sequencer_start_bit;
    wire [15:0] pulses = {o_converter_sample_trigger, o_capture_sync_pulse,
        o_compare_clock_pulse, o_compare_sync_pulse};
    default clocking @(posedge i_ref_clk); endclocking
    default disable iff (i_rst);
    // pointer load only counts while the sequencer runs
    sequence s_load; i_pointer_load && run; endsequence
    chk_rd_idle: assert property (!$past(i_rd) |-> o_rdata == 16'h0000)
        else $error("read data not zero outside read slot");
    chk_pulse_cause: assert property (pulses != 16'h0000 |-> $past(i_step_execute && run))
        else $error("trigger pulse without executed step");
    chk_pulse_once: assert property (pulses != 16'h0000 && !(i_step_execute && run)
        |=> pulses == 16'h0000) else $error("trigger pulse longer than one cycle");
    chk_ro_limit: assert property ($past(run) && !$past(i_step_execute)
        |=> $stable(o_timer0_limit)) else $error("limit changed while running");
    chk_delay_sum: assert property (i_rd && i_addr == ADDR_SDELAY_LIM
        && !i_live_count_visibility |=> o_step_delay_total == {1'b0, o_rdata} + 17'h00001)
        else $error("step delay total not limit plus one");
    chk_vis_live: assert property (i_rd && i_addr == ADDR_TIMER0_LIM
        && i_live_count_visibility |=> o_rdata == $past(i_timer0_count))
        else $error("visible read did not return live count");
    chk_ptr_top: assert property (i_rd && i_addr == ADDR_POINTER
        |=> o_rdata[15:5] == 11'h000) else $error("pointer upper bits not zero");
    chk_ptr_load: assert property (s_load |-> ##2
        o_step_index_pointer == $past(i_pointer_value, 2)) else $error("pointer load lost");
endmodule
bind trigger_seq_regs trigger_seq_regs_checker u_checker (
    .i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_addr(i_addr), .i_rd(i_rd), .o_rdata(o_rdata),
    .i_module_enable_bit(i_module_enable_bit), .i_sequencer_start_bit(i_sequencer_start_bit),
    .i_live_count_visibility(i_live_count_visibility), .i_timer0_count(i_timer0_count),
    .i_step_execute(i_step_execute), .i_pointer_load(i_pointer_load),
    .i_pointer_value(i_pointer_value), .o_step_index_pointer(o_step_index_pointer),
    .o_timer0_limit(o_timer0_limit), .o_step_delay_total(o_step_delay_total),
    .o_converter_sample_trigger(o_converter_sample_trigger),
    .o_capture_sync_pulse(o_capture_sync_pulse), .o_compare_clock_pulse(o_compare_clock_pulse),
    .o_compare_sync_pulse(o_compare_sync_pulse)
);

// >>> tb/seq_core_model.sv
/*
 * behavioural sequencer core facing the bank: run control, pointer
 * loads, step execution and a live count. assumes one step request at a time.
 */
`timescale 1ns/10ps
module seq_core_model (
    // clock, reset and bench requests
    input wire logic i_ref_clk,
    input wire logic i_rst,
    input wire logic i_run,
    input wire logic i_go,
    input wire logic [4:0] i_idx,
    // signals into the bank
    output logic o_module_enable_bit,
    output logic o_sequencer_start_bit,
    output logic o_pointer_load,
    output logic [4:0] o_pointer_value,
    output logic o_step_execute,
    output logic [15:0] o_tick
);
    // ----------------------------------------
    // run control and step issue
    // ----------------------------------------
    // start follows enable by a cycle, never set in the same write
    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            o_module_enable_bit <= 1'b0;
            o_sequencer_start_bit <= 1'b0;
            o_pointer_load <= 1'b0;
            o_pointer_value <= 5'h00;
            o_step_execute <= 1'b0;
            o_tick <= 16'h0000;
        end else begin
            o_module_enable_bit <= i_run;
            o_sequencer_start_bit <= i_run & o_module_enable_bit;
            o_pointer_load <= i_go;
            o_pointer_value <= i_go ? i_idx : ~o_pointer_value; // idle lines wander
            o_step_execute <= o_pointer_load;
            if (o_sequencer_start_bit) begin
                o_tick <= o_tick + 16'h0001;
            end
        end
    end
endmodule

// >>> tb/trigger_seq_regs_bench.sv
/*
 * self-checking bench for the trigger sequencer register bank.
 * assumes package, bank, core model and checker are compiled first.
 */
`timescale 1ns/10ps
module trigger_seq_regs_bench;
    import trigger_seq_pkg::*;
    // ----------------------------------------
    // stimulus, instances and checks
    // ----------------------------------------
    logic i_ref_clk = 1'b0;
    logic i_rst = 1'b1;
    logic [5:0] addr = 6'h00;
    logic [15:0] wdata = 16'h0000;
    logic wr = 1'b0, rd = 1'b0, run = 1'b0, vis = 1'b0, go = 1'b0;
    logic [4:0] idx = 5'h00, ptr_val, ptr;
    logic en, start, load, exec, strobe;
    logic [3:0] cmd, opt, adc, ic, occ, ocs;
    logic [15:0] rdata, tick, chan, t0_lim, t1_lim, c0_lim, c1_lim;
    logic [16:0] total;
    int fail_count = 0;
    int n_compared = 0;
    wire [15:0] pulses = {adc, ic, occ, ocs};
    // rows: address, write data, expected read back
    logic [39:0] rows [16] = '{40'h00_a5c3_a5c3, 40'h01_ffff_ffff, 40'h02_8001_8001,
        40'h03_ffff_ffff, 40'h04_0001_0001, 40'h05_fffe_fffe, 40'h06_1234_1234,
        40'h07_0003_0003, 40'h08_0055_0055, 40'h09_ffff_001f, 40'h0a_5a5a_0000,
        40'h10_180f_180f, 40'h11_0c10_0c10, 40'h12_1f0e_1f0e, 40'h1f_c3c3_c3c3,
        40'h20_7777_0000};
    always #12.5 i_ref_clk = ~i_ref_clk;
    seq_core_model u_seq_core_model (.i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_run(run),
        .i_go(go), .i_idx(idx), .o_module_enable_bit(en), .o_sequencer_start_bit(start),
        .o_pointer_load(load), .o_pointer_value(ptr_val), .o_step_execute(exec),
        .o_tick(tick));
    trigger_seq_regs u_trigger_seq_regs (.i_ref_clk(i_ref_clk), .i_rst(i_rst),
        .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata),
        .i_module_enable_bit(en), .i_sequencer_start_bit(start),
        .i_live_count_visibility(vis), .i_timer0_count(tick),
        .i_timer1_count(tick ^ 16'h00ff), .i_step_delay_count(~tick),
        .i_counter0_count(tick ^ 16'h0f0f), .i_counter1_count(tick ^ 16'hf0f0),
        .i_step_execute(exec), .i_pointer_load(load), .i_pointer_value(ptr_val),
        .o_step_command(cmd), .o_step_option(opt), .o_step_index_pointer(ptr),
        .o_timer0_limit(t0_lim), .o_timer1_limit(t1_lim), .o_step_delay_total(total),
        .o_counter0_limit(c0_lim), .o_counter1_limit(c1_lim),
        .o_converter_sample_trigger(adc), .o_capture_sync_pulse(ic),
        .o_compare_clock_pulse(occ), .o_compare_sync_pulse(ocs),
        .o_converter_channel_select(chan), .o_converter_channel_strobe(strobe));
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            fail_count++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // one idle edge after each strobe so a strobe is never set twice at once
    task automatic wr_reg(input logic [5:0] a, input logic [15:0] d);
        @(posedge i_ref_clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge i_ref_clk);
        wr <= 1'b0;
    endtask
    task automatic rd_reg(input logic [5:0] a, input logic [15:0] exp);
        @(posedge i_ref_clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge i_ref_clk);
        rd <= 1'b0;
        #1;
        cmp(rdata, exp);
    endtask
    // ask the core for step n, return just after the bank has acted on it
    task automatic step(input logic [4:0] n);
        @(posedge i_ref_clk);
        idx <= n;
        go <= 1'b1;
        @(posedge i_ref_clk);
        go <= 1'b0;
        for (int k = 0; k < 8; k++) begin
            @(posedge i_ref_clk);
            if (exec === 1'b1) break;
        end
        #1;
    endtask
    task automatic settle;
        @(posedge i_ref_clk);
        #1;
    endtask
    task automatic tally_and_finish;
        if (fail_count == 0 && n_compared > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    // whole run is well under a thousand cycles
    initial begin
        repeat (4000) @(posedge i_ref_clk);
        fail_count++;
        tally_and_finish;
    end
    initial begin
        repeat (3) @(posedge i_ref_clk);
        i_rst <= 1'b0;
        foreach (rows[i]) begin
            wr_reg(rows[i][37:32], rows[i][31:16]);
            rd_reg(rows[i][37:32], rows[i][15:0]);
        end
        cmp(total, 17'h10000);
        cmp({t1_lim, t0_lim}, 32'h8001_ffff);
        cmp(c1_lim, 16'hfffe);
        run <= 1'b1;
        repeat (4) @(posedge i_ref_clk);
        wr_reg(ADDR_TIMER0_LIM, 16'h0000);
        wr_reg(ADDR_BCAST_MASK, 16'h0000);
        rd_reg(ADDR_TIMER0_LIM, 16'hffff);
        rd_reg(ADDR_BCAST_MASK, 16'ha5c3);
        step(5'h00);
        cmp(pulses, 16'ha5c3);
        settle;
        cmp(pulses, 16'h0000);
        step(5'h01);
        settle;
        cmp(c0_lim, 16'h1234);
        step(5'h02);
        settle;
        cmp(c0_lim, 16'h1237);
        step(5'h03);
        cmp({strobe, chan}, 17'h11237);
        step(5'h04);
        cmp({strobe, chan}, 17'h10055);
        step(5'h05);
        cmp({strobe, pulses}, 17'h00000);
        rd_reg(ADDR_POINTER, 16'h0005);
        cmp({ptr, cmd, opt}, 13'h051f);
        run <= 1'b0;
        repeat (3) @(posedge i_ref_clk);
        step(5'h00);
        cmp(pulses, 16'h0000);
        vis <= 1'b1;
        rd_reg(ADDR_TIMER0_LIM, tick);
        rd_reg(ADDR_SDELAY_LIM, ~tick);
        vis <= 1'b0;
        wr_reg(ADDR_TIMER0_LIM, 16'h4321);
        rd_reg(ADDR_TIMER0_LIM, 16'h4321);
        run <= 1'b1;
        repeat (4) @(posedge i_ref_clk);
        i_rst <= 1'b1;
        run <= 1'b0;
        repeat (3) @(posedge i_ref_clk);
        i_rst <= 1'b0;
        #1;
        cmp(total, 17'h00001);
        for (int a = 0; a < 64; a++) begin
            rd_reg(6'(a), 16'h0000);
        end
        tally_and_finish;
    end
endmodule
